// *** two_wire_slave.sv ***
`timescale 1ns/10ps
module two_wire_slave
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h2a  // arbitrary value
) (
    input  wire logic                         ref_clk,
    input  wire logic                         resetn,
    input  wire logic                         sclIn,
    input  wire logic                         sdaIn,
    output logic                              sdaOut,
    output logic                              sdaOeN,
    output charger_regs_pkg::reg_access_t     access,
    input  wire logic [7:0]                   readData
);
    import charger_regs_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0]  sclSync;
    logic [2:0]  sdaSync;
    logic        sclS;
    logic        sdaS;
    logic        sclPrev;
    logic        sdaPrev;
    logic        sclRise;
    logic        sclFall;
    logic        startSeen;
    logic        stopSeen;
    link_state_t state;
    link_state_t afterAck;
    logic [7:0]  shiftReg;
    logic [2:0]  bitCnt;
    logic        byteFull;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sclSync <= 3'h7;
            sdaSync <= 3'h7;
            sclS    <= 1'b1;
            sdaS    <= 1'b1;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclSync <= {sclSync[1:0], sclIn};
            sdaSync <= {sdaSync[1:0], sdaIn};
            // glitch filter: a change counts once two stages agree
            if (sclSync[2] == sclSync[1]) begin
                sclS <= sclSync[2];
            end
            if (sdaSync[2] == sdaSync[1]) begin
                sdaS <= sdaSync[2];
            end
            sclPrev <= sclS;
            sdaPrev <= sdaS;
        end
    end

    assign sclRise   = sclS & ~sclPrev;
    assign sclFall   = ~sclS & sclPrev;
    assign startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
    assign stopSeen  = sclS & sclPrev & ~sdaPrev & sdaS;

    // ----------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state    <= ST_IDLE;
            afterAck <= ST_IDLE;
            shiftReg <= 8'h00;
            bitCnt   <= 3'h0;
            byteFull <= 1'b0;
            sdaOut   <= 1'b0;
            sdaOeN   <= 1'b1;
            access   <= '0;
        end else begin
            access.wrStrobe <= 1'b0;
            access.rdStrobe <= 1'b0;
            if (startSeen) begin
                state    <= ST_ADDR;
                bitCnt   <= 3'h0;
                byteFull <= 1'b0;
                sdaOeN   <= 1'b1;
            end else if (stopSeen) begin
                state  <= ST_IDLE;
                sdaOeN <= 1'b1;
            end else begin
                case (state)
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        if (sclRise) begin
                            shiftReg <= {shiftReg[6:0], sdaS};
                            bitCnt   <= bitCnt + 3'h1;
                            byteFull <= (bitCnt == LAST_BIT);
                        end else if (sclFall && byteFull) begin
                            byteFull <= 1'b0;
                            sdaOeN   <= 1'b0;
                            state    <= ST_ACK;
                            if (state == ST_ADDR) begin
                                afterAck <= shiftReg[0] ? ST_RDATA : ST_REG;
                                if (shiftReg[7:1] != DEVICE_ADDR) begin
                                    // not ours: stay off the wire
                                    sdaOeN <= 1'b1;
                                    state  <= ST_IDLE;
                                end
                            end else if (state == ST_REG) begin
                                access.addr <= shiftReg;
                                afterAck    <= ST_WDATA;
                            end else begin
                                access.wrStrobe <= 1'b1;
                                access.wdata    <= shiftReg;
                                afterAck        <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (access.wrStrobe) begin
                            access.addr <= access.addr + 8'h01;
                        end
                        if (sclFall) begin
                            bitCnt <= 3'h0;
                            state  <= afterAck;
                            if (afterAck == ST_RDATA) begin
                                shiftReg        <= readData;
                                sdaOeN          <= readData[7];
                                access.rdStrobe <= 1'b1;
                            end else begin
                                sdaOeN <= 1'b1;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (access.rdStrobe) begin
                            access.addr <= access.addr + 8'h01;
                        end
                        if (sclFall) begin
                            bitCnt <= bitCnt + 3'h1;
                            if (bitCnt == LAST_BIT) begin
                                sdaOeN <= 1'b1;
                                state  <= ST_MACK;
                            end else begin
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                sdaOeN   <= shiftReg[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (sclRise) begin
                            // master nack ends the read
                            state    <= sdaS ? ST_IDLE : ST_ACK;
                            afterAck <= ST_RDATA;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // two_wire_slave

// *** charger_regs_pkg.sv ***
package charger_regs_pkg;

    // ----------------------------------------------------------------
    // register offsets on the two-wire bus
    // ----------------------------------------------------------------
    localparam logic [7:0] FLAG_OFFSET   = 8'h06;
    localparam logic [7:0] MASK_OFFSET   = 8'h07;
    localparam logic [7:0] THERM_OFFSET  = 8'h20;
    localparam logic [7:0] INPUT_OFFSET  = 8'h21;

    // ----------------------------------------------------------------
    // reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_RESET    = 8'hff;
    localparam logic [7:0] THERM_RESET   = 8'h0f;
    localparam logic [7:0] INPUT_RESET   = 8'h00;
    localparam int         FLAG_COUNT    = 7;
    localparam int         HOT_LSB       = 6;
    localparam int         WARM_LSB      = 4;
    localparam int         COOL_LSB      = 2;
    localparam int         COLD_LSB      = 0;
    localparam int         VMIN_LSB      = 5;
    localparam int         ILIM_LSB      = 2;
    localparam int         PRECHARGE_BIT = 1;
    localparam int         ENABLE_BIT    = 0;
    localparam logic [2:0] ILIM_TOP_CODE = 3'h4;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    localparam logic [7:0] READ_EMPTY    = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wrStrobe;
        logic       rdStrobe;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;

    typedef struct packed {
        logic [1:0] hot_threshold_select;
        logic [1:0] warm_threshold_select;
        logic [1:0] cool_threshold_select;
        logic [1:0] cold_threshold_select;
        logic [2:0] input_min_voltage_select;
        logic [2:0] currentLimitStep;
        logic       precharge_current_select;
        logic       charger_enable;
    } charger_settings_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
    } link_state_t;

endpackage

// *** charger_irq_mask_and_config_regs.sv ***
`timescale 1ns/10ps
//
// Notes on behaviour
// R01: mask bits 6..4 gate system-config, system-control, input-control flags from irq
// R02: mask bits 3..0 gate junction-temp, input-status, charger-status, thermistor flags
// R03: mask 0 lets a flag through, 1 blocks it; all mask bits reset high
// R04: software writes 0 to mask bit 7; its read value means nothing
// R05: thermistor bits 7:6 pick hot threshold, reset 00
// R06: thermistor bits 5:4 pick warm threshold, reset 00
// R07: thermistor bits 3:2 pick cool threshold, reset 11
// R08: thermistor bits 1:0 pick cold threshold, reset 11
// R09: input bits 7:5 pick minimum input voltage 4.0V..4.7V, reset 000
// R10: input bits 4:2 pick current limit 95mA..475mA when order select low
// R11: current limit codes 101..111 act as code 100
// R12: order select high reverses the current limit mapping
// R13: input bit 1 picks precharge 10% or 20%, reset 0
// R14: input bit 0 enables the charger when high
// R15: charger enable loads its reset value from the factory option
// R16: masking gates only irq; flags keep latching and stay readable
//
module charger_irq_mask_and_config_regs
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h2a  // arbitrary value
) (
    input  wire logic                              ref_clk,
    input  wire logic                              resetn,
    input  wire logic                              sclIn,
    input  wire logic                              sdaIn,
    output logic                                   sdaOut,
    output logic                                   sdaOeN,
    input  wire logic [6:0]                        flagEvents,
    input  wire logic                              chargerEnableOtp,
    input  wire logic                              current_limit_order_select,
    output logic                                   irq,
    output logic [6:0]                             flagView,
    output charger_regs_pkg::charger_settings_t    settings
);
    import charger_regs_pkg::*;

    // ----------------------------------------------------------------
    // bus access
    // ----------------------------------------------------------------
    reg_access_t access;
    logic [7:0]  readData;
    logic [7:0]  charger_interrupt_mask;
    logic [7:0]  thermistor_threshold_config;
    logic [7:0]  charger_input_config;
    logic [6:0]  flags;
    logic [6:0]  flagsShown;
    logic [6:0]  pending;
    logic        flagCleared;
    logic        maskWrite;
    logic        thermWrite;
    logic        inputWrite;
    logic [2:0]  clampedLimit;

    function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction

    two_wire_slave #(
        .DEVICE_ADDR (DEVICE_ADDR)
    ) link (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .sclIn    (sclIn),
        .sdaIn    (sdaIn),
        .sdaOut   (sdaOut),
        .sdaOeN   (sdaOeN),
        .access   (access),
        .readData (readData)
    );

    always_comb begin
        readData = READ_EMPTY;
        if (hits(access.addr, FLAG_OFFSET)) begin
            readData = {1'b0, flags};
        end else if (hits(access.addr, MASK_OFFSET)) begin
            readData = charger_interrupt_mask;
        end else if (hits(access.addr, THERM_OFFSET)) begin
            readData = thermistor_threshold_config;
        end else if (hits(access.addr, INPUT_OFFSET)) begin
            readData = charger_input_config;
        end
    end

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    // one strobe per register; the pointer already holds the target
    assign maskWrite   = access.wrStrobe && hits(access.addr, MASK_OFFSET);
    assign thermWrite  = access.wrStrobe && hits(access.addr, THERM_OFFSET);
    assign inputWrite  = access.wrStrobe && hits(access.addr, INPUT_OFFSET);
    // clear strobe follows the edge that loaded the flag byte for shifting
    assign flagCleared = access.rdStrobe && hits(access.addr, FLAG_OFFSET);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            // R03 mask resets high
            charger_interrupt_mask <= MASK_RESET;
        end else if (maskWrite) begin
            // R04 bit 7 stored as written, no effect
            charger_interrupt_mask <= access.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            // R07 R08 cool and cold reset to 11
            thermistor_threshold_config <= THERM_RESET;
        end else if (thermWrite) begin
            thermistor_threshold_config <= access.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            charger_input_config             <= INPUT_RESET;
            // R15 enable from factory option
            charger_input_config[ENABLE_BIT] <= chargerEnableOtp;
        end else if (inputWrite) begin
            charger_input_config <= access.wdata;
        end
    end

    // ----------------------------------------------------------------
    // event flags and interrupt
    // ----------------------------------------------------------------
    // what the read byte carried out: flags as they stood one edge before the clear
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            flagsShown <= '0;
        end else begin
            flagsShown <= flags;
        end
    end

    // clear on read drops only shown flags, so an event just before it is not lost
    for (genvar f = 0; f < FLAG_COUNT; f++) begin : g_flag
        always_ff @(posedge ref_clk) begin
            if (!resetn) begin
                flags[f] <= 1'b0;
            end else if (flagEvents[f]) begin
                // R16 latch regardless of mask, set wins
                flags[f] <= 1'b1;
            end else if (flagCleared && flagsShown[f]) begin
                flags[f] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    // R01 R02 R03 per-flag mask gate
    for (genvar f = 0; f < FLAG_COUNT; f++) begin : g_gate
        assign pending[f] = flags[f] & ~charger_interrupt_mask[f];
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq      <= 1'b0;
            flagView <= '0;
        end else begin
            // R01 R02 R03 mask gates output only
            irq      <= |pending;
            flagView <= flags;
        end
    end

    // ----------------------------------------------------------------
    // decoded settings
    // ----------------------------------------------------------------
    // R11 reserved codes clamp to top code
    // clamped before the order flip, so a reserved code tracks code 100 either way
    assign clampedLimit = (charger_input_config[ILIM_LSB+2:ILIM_LSB] > ILIM_TOP_CODE)
                        ? ILIM_TOP_CODE : charger_input_config[ILIM_LSB+2:ILIM_LSB];

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            settings.hot_threshold_select  <= '0;
            settings.warm_threshold_select <= '0;
            settings.cool_threshold_select <= '0;
            settings.cold_threshold_select <= '0;
        end else begin
            // R05 R06 R07 R08 threshold selects
            settings.hot_threshold_select  <= thermistor_threshold_config[HOT_LSB+1:HOT_LSB];
            settings.warm_threshold_select <= thermistor_threshold_config[WARM_LSB+1:WARM_LSB];
            settings.cool_threshold_select <= thermistor_threshold_config[COOL_LSB+1:COOL_LSB];
            settings.cold_threshold_select <= thermistor_threshold_config[COLD_LSB+1:COLD_LSB];
        end
    end

    // ----------------------------------------------------------------
    // input settings
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            settings.input_min_voltage_select <= '0;
            settings.currentLimitStep         <= '0;
            settings.precharge_current_select <= 1'b0;
            settings.charger_enable           <= 1'b0;
        end else begin
            // R09 minimum input voltage
            settings.input_min_voltage_select <= charger_input_config[VMIN_LSB+2:VMIN_LSB];
            // R10 R12 step n means 95mA times n+1
            settings.currentLimitStep <= current_limit_order_select
                                       ? ILIM_TOP_CODE - clampedLimit : clampedLimit;
            // R13 precharge fraction
            settings.precharge_current_select <= charger_input_config[PRECHARGE_BIT];
            // R14 charger enable
            settings.charger_enable <= charger_input_config[ENABLE_BIT];
        end
    end

endmodule // charger_irq_mask_and_config_regs

// *** charger_irq_mask_and_config_regs_assertions.sv ***
`timescale 1ns/10ps
module charger_irq_mask_and_config_regs_assertions
    import charger_regs_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h2a  // arbitrary value
) (
    input wire logic                                ref_clk,
    input wire logic                                resetn,
    input wire logic                                sclIn,
    input wire logic                                sdaIn,
    input wire logic                                sdaOut,
    input wire logic                                sdaOeN,
    input wire logic [6:0]                          flagEvents,
    input wire logic                                chargerEnableOtp,
    input wire logic                                current_limit_order_select,
    input wire logic                                irq,
    input wire logic [6:0]                          flagView,
    input wire charger_regs_pkg::charger_settings_t settings
);
    import charger_regs_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    // no bus edge and no order change for a while: no flag may drop and no setting may move
    sequence quietBus;
        (resetn && $stable(sclIn) && $stable(current_limit_order_select)) [*8];
    endsequence
    sequence flagRaised;
        flagEvents != 7'h00;
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    // events always latch
    flag_latch_a:
    assert property (flagRaised |=> ##1 (flagView & $past(flagEvents, 2)) == $past(flagEvents, 2))
        else $error("event not latched into flag view");
    flag_hold_a:
    assert property (quietBus |=> (flagView & $past(flagView)) == $past(flagView))
        else $error("flag dropped without bus traffic");
    irq_source_a:
    assert property (irq |-> flagView != 7'h00)
        else $error("irq without any latched flag");
    irq_drop_a:
    assert property (flagView == 7'h00 && $past(flagEvents) == 7'h00 |=> !irq)
        else $error("irq stayed high with no flag");
    reset_quiet_a:
    assert property (disable iff (1'b0) !resetn |=> (!irq && sdaOeN && flagView == 7'h00))
        else $error("outputs not quiet after reset cycle");
    reset_config_a:
    assert property ($rose(resetn) |-> ##[0:2] (settings[15:8] == THERM_RESET
        && settings[7:5] == 3'h0 && !settings.precharge_current_select
        && settings.charger_enable == chargerEnableOtp))
        else $error("settings not at reset configuration");
    limit_clamp_a:
    assert property (settings.currentLimitStep <= ILIM_TOP_CODE)
        else $error("current limit step above top code");
    settings_hold_a:
    assert property (quietBus |=> $stable(settings))
        else $error("settings moved without a write");
endmodule // charger_irq_mask_and_config_regs_assertions

bind charger_irq_mask_and_config_regs charger_irq_mask_and_config_regs_assertions #(
    .DEVICE_ADDR(DEVICE_ADDR)
) u_checker (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOeN(sdaOeN),
    .flagEvents(flagEvents),
    .chargerEnableOtp(chargerEnableOtp),
    .current_limit_order_select(current_limit_order_select),
    .irq(irq),
    .flagView(flagView),
    .settings(settings)
);

// *** charger_irq_mask_and_config_regs_bench.sv ***
`timescale 1ns/10ps
module charger_irq_mask_and_config_regs_bench;
    import charger_regs_pkg::*;
    localparam logic [6:0] DEV  = 7'h2a;  // arbitrary value
    localparam int         HALF = 6;
    logic              ref_clk = 1'b0;
    logic              resetn = 1'b0;
    logic              scl = 1'b1;
    logic              sdaM = 1'b1;
    logic [6:0]        flagEvents = 7'h00;
    logic              chargerEnableOtp = 1'b0;
    logic              current_limit_order_select = 1'b0;
    logic              sdaOut;
    logic              sdaOeN;
    logic              irq;
    logic [6:0]        flagView;
    charger_settings_t settings;
    logic [7:0]        rd;
    logic [2:0]        step;
    int                err_total = 0;
    int                comparisons = 0;
    // pulled-up line, low when either side pulls
    wire sdaLine = sdaM & (sdaOeN | sdaOut);

    always #2 ref_clk = ~ref_clk;

    charger_irq_mask_and_config_regs #(.DEVICE_ADDR(DEV)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .flagEvents(flagEvents),
        .chargerEnableOtp(chargerEnableOtp),
        .current_limit_order_select(current_limit_order_select),
        .irq(irq), .flagView(flagView), .settings(settings)
    );
    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // data moves two cycles after the clock fall, never with it
    task automatic sendBit(input logic b);
        tick(2);
        sdaM = b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask
    task automatic getBit(output logic b);
        tick(2);
        sdaM = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF / 2);
        b = sdaLine;
        tick(HALF / 2);
        scl = 1'b0;
    endtask
    task automatic sendByte(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) sendBit(v[i]);
        getBit(a);
    endtask
    task automatic startCond();
        tick(2);
        sdaM = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sdaM = 1'b0;
        tick(HALF);
        scl = 1'b0;
    endtask
    task automatic stopCond();
        tick(2);
        sdaM = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sdaM = 1'b1;
        tick(HALF);
    endtask
    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        startCond();
        sendByte({DEV, 1'b0});
        sendByte(a);
        sendByte(d);
        stopCond();
    endtask
    task automatic checkReg(input logic [7:0] a, input logic [7:0] exp,
                            input logic [7:0] care = 8'hff);
        logic b;
        startCond();
        sendByte({DEV, 1'b0});
        sendByte(a);
        startCond();
        sendByte({DEV, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            getBit(b);
            rd[i] = b;
        end
        sendBit(1'b1);
        stopCond();
        check(rd & care, exp & care);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(input logic [6:0] v);
        flagEvents = v;
        tick(1);
        flagEvents = 7'h00;
        tick(3);
    endtask
    task automatic doReset();
        resetn = 1'b0;
        tick(12);
        resetn = 1'b1;
        tick(6);
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        doReset();
        checkReg(MASK_OFFSET, MASK_RESET, 8'h7f);
        checkReg(THERM_OFFSET, THERM_RESET);
        checkReg(INPUT_OFFSET, 8'h00);
        check(settings[15:8], 8'h0f);
        checkReg(8'h30, READ_EMPTY);
        for (int i = 0; i < 8; i++) begin
            writeReg(THERM_OFFSET, 8'h1b << i);
            check(settings[15:8], 8'h1b << i);
        end
        checkReg(THERM_OFFSET, 8'h80);
        // reserved codes clamp first, then the order flips
        for (int o = 0; o < 2; o++) begin
            current_limit_order_select = o[0];
            for (int c = 0; c < 8; c++) begin
                step = (c > 4) ? ILIM_TOP_CODE : c[2:0];
                if (o == 1) step = ILIM_TOP_CODE - step;
                writeReg(INPUT_OFFSET, {3'h5, c[2:0], 2'b10});
                check({5'h0, settings.currentLimitStep}, {5'h0, step});
            end
        end
        check(settings[7:0] & 8'he3, 8'ha2);
        writeReg(INPUT_OFFSET, 8'he1);
        checkReg(INPUT_OFFSET, 8'he1);
        check(settings[7:0] & 8'he3, 8'he1);
        for (int i = 0; i < FLAG_COUNT; i++) begin
            writeReg(MASK_OFFSET, 8'h7f & ~(8'h01 << i));
            pulse(7'h7f & ~(7'h01 << i));
            check({7'h0, irq}, 8'h00);
            check({1'b0, flagView}, 8'h7f & ~(8'h01 << i));
            pulse(7'h01 << i);
            check({7'h0, irq}, 8'h01);
            checkReg(FLAG_OFFSET, 8'h7f);
            tick(3);
            check({7'h0, irq}, 8'h00);
        end
        chargerEnableOtp = 1'b1;
        doReset();
        checkReg(INPUT_OFFSET, 8'h01);
        check({7'h0, settings.charger_enable}, 8'h01);
        results();
    end

    initial begin
        // tests need about 85.5 us, a little under half of this span
        #200000;
        err_total++;
        results();
    end
endmodule // charger_irq_mask_and_config_regs_bench
